// [rtl/rtcal_alarm0.sv]
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// RL1: Alarm 0 events occur only while the enable bit 5 of control is set.
// RL2: Match bit 7 enables the field; low bits hold BCD value; zero excludes.
// RL3: Compare only when the running time advances into a new second.
// RL4: A match sets the alarm 0 flag and drives the output pin low.
// RL5: Mode bit 7 set gives a pin pulse on every match, repeating.
// RL6: Pulsed mode sets the flag each trigger; clearing it is not required.
// RL7: Mode bit clear gives a single-event alarm held until flag clear.
// RL8: Host uses read-modify-write on control to keep other bits intact.
module rtcal_alarm0
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire rtcal_pkg::rtcal_apb_req_t apbReq,
  output rtcal_pkg::rtcal_apb_rsp_t apbRsp,
  input  wire rtcal_pkg::rtcal_time_t    timeNow,
  input  wire logic                 timeAdvance,
  output logic                      alarmOrClockOutPinN,
  output logic                      irq
);

  logic [7:0]                  secMatch_ff;
  logic [7:0]                  minMatch_ff;
  logic [7:0]                  hrMatch_ff;
  logic [7:0]                  dtMatch_ff;
  logic [7:0]                  moMatch_ff;
  logic [7:0]                  wdMatch_ff;
  logic [7:0]                  ctrl_ff;
  logic [0:0]                  alarm0Flag_ff;
  logic [0:0]                  irqEn_ff;
  logic [7:0]                  pulseCnt_ff;
  logic [7:0]                  nxt_pulseCnt;
  logic [31:0]                 prdata_ff;
  logic [31:0]                 nxt_prdata;
  logic                        pslverr_ff;
  logic                        pinN_ff;
  logic                        nxt_pinN;
  rtcal_pkg::rtcal_pin_state_t pinState_ff;
  rtcal_pkg::rtcal_pin_state_t nxt_pinState;
  logic                        setupPhase;
  logic                        wrStrobe;
  logic                        mapped;
  logic                        anyFieldOn;
  logic                        allMatch;
  logic                        alarmEnable;
  logic                        pulseMode;
  logic                        alarmEvent;
  logic                        flagClear;

  // The pulse length is a whole number of clock cycles, rounded up.
  localparam logic [7:0] CNT_LOAD = 8'(rtcal_pkg::PULSE_CYCLES);

  function automatic logic fieldOn
  (
    input logic [7:0] matchReg
  );
    return matchReg[rtcal_pkg::MATCH_EN_BIT];
  endfunction

  // A field with its enable bit clear always matches.
  function automatic logic fieldMatch
  (
    input logic [7:0] matchReg,
    input logic [7:0] nowVal
  );
    logic hit;
    hit = matchReg[rtcal_pkg::MATCH_VAL_MSB:0]
          == nowVal[rtcal_pkg::MATCH_VAL_MSB:0];
    return !fieldOn(matchReg) || hit;
  endfunction

  // Unmapped offsets answer with an error and read as zero.
  function automatic logic isMapped
  (
    input logic [7:0] addr
  );
    logic ok;
    case (addr)
      rtcal_pkg::OFS_SEC_MATCH,
      rtcal_pkg::OFS_MIN_MATCH,
      rtcal_pkg::OFS_HR_MATCH,
      rtcal_pkg::OFS_DT_MATCH,
      rtcal_pkg::OFS_MO_MATCH,
      rtcal_pkg::OFS_WD_MATCH,
      rtcal_pkg::OFS_IRQ_CTRL,
      rtcal_pkg::OFS_STATUS,
      rtcal_pkg::OFS_CLEAR,
      rtcal_pkg::OFS_IRQ_EN:
        ok = 1'b1;
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  // One decode for the control, interrupt enable and clear writes keeps the strobes consistent.
  function automatic logic regWrite
  (
    input logic       strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && addr == target;
  endfunction

  // The slave answers in the first access cycle, so pready is always high.
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign mapped     = isMapped(apbReq.paddr);
  assign wrStrobe   = apbReq.psel && apbReq.penable && apbReq.pwrite
                      && mapped;

  assign apbRsp = '{prdata:  prdata_ff,
                    pready:  1'b1,
                    pslverr: pslverr_ff};

  // Match registers are plain storage; the compare reads them every cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      secMatch_ff <= rtcal_pkg::REG_RST;
      minMatch_ff <= rtcal_pkg::REG_RST;
      hrMatch_ff  <= rtcal_pkg::REG_RST;
      dtMatch_ff  <= rtcal_pkg::REG_RST;
      moMatch_ff  <= rtcal_pkg::REG_RST;
      wdMatch_ff  <= rtcal_pkg::REG_RST;
    end
    else if (wrStrobe)
    begin
      case (apbReq.paddr)
        rtcal_pkg::OFS_SEC_MATCH: secMatch_ff <= apbReq.pwdata[7:0];
        rtcal_pkg::OFS_MIN_MATCH: minMatch_ff <= apbReq.pwdata[7:0];
        rtcal_pkg::OFS_HR_MATCH:  hrMatch_ff  <= apbReq.pwdata[7:0];
        rtcal_pkg::OFS_DT_MATCH:  dtMatch_ff  <= apbReq.pwdata[7:0];
        rtcal_pkg::OFS_MO_MATCH:  moMatch_ff  <= apbReq.pwdata[7:0];
        rtcal_pkg::OFS_WD_MATCH:  wdMatch_ff  <= apbReq.pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // All eight bits are kept, so bits outside enable and mode survive a
  // read-modify-write by the host.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_ff <= rtcal_pkg::REG_RST;
    end
    else if (regWrite(wrStrobe, apbReq.paddr, rtcal_pkg::OFS_IRQ_CTRL))
    begin
      ctrl_ff <= apbReq.pwdata[7:0]; // [RL8]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqEn_ff <= rtcal_pkg::STAT_RST;
    end
    else if (regWrite(wrStrobe, apbReq.paddr, rtcal_pkg::OFS_IRQ_EN))
    begin
      irqEn_ff <= apbReq.pwdata[rtcal_pkg::STAT_AL0_BIT];
    end
  end

  assign alarmEnable = ctrl_ff[rtcal_pkg::CTRL_ALARM0_ENABLE_BIT];
  assign pulseMode   = ctrl_ff[rtcal_pkg::CTRL_IM_BIT];

  // A register of all zero excludes its field; with no field enabled the
  // alarm would fire every second, which is treated as not armed.
  assign anyFieldOn = fieldOn(secMatch_ff)
                      || fieldOn(minMatch_ff)
                      || fieldOn(hrMatch_ff)
                      || fieldOn(dtMatch_ff)
                      || fieldOn(moMatch_ff)
                      || fieldOn(wdMatch_ff); // [RL2]

  assign allMatch = fieldMatch(secMatch_ff, timeNow.second)
                    && fieldMatch(minMatch_ff, timeNow.minute)
                    && fieldMatch(hrMatch_ff, timeNow.hour)
                    && fieldMatch(dtMatch_ff, timeNow.date)
                    && fieldMatch(moMatch_ff, timeNow.month)
                    && fieldMatch(wdMatch_ff, timeNow.weekday); // [RL2]

  // Single-event mode ignores matches while the previous flag is pending;
  // pulsed mode triggers on every match.
  assign alarmEvent = timeAdvance && anyFieldOn && allMatch // [RL3]
                      && alarmEnable // [RL1]
                      && (pulseMode || !alarm0Flag_ff[0]); // [RL7] [RL5]

  assign flagClear = regWrite(wrStrobe, apbReq.paddr, rtcal_pkg::OFS_CLEAR)
                     && apbReq.pwdata[rtcal_pkg::STAT_AL0_BIT];

  // The set wins when an event and a clear meet in one cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alarm0Flag_ff <= rtcal_pkg::STAT_RST;
    end
    else if (alarmEvent)
    begin
      alarm0Flag_ff <= 1'h1; // [RL4] [RL6]
    end
    else if (flagClear)
    begin
      alarm0Flag_ff <= rtcal_pkg::STAT_RST;
    end
  end

  // The interrupt is registered so it never glitches; as a limitation it
  // trails the flag by one cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(alarm0Flag_ff & irqEn_ff);
    end
  end

  // A match inside a running pulse restarts the count, so close alarms
  // merge into one longer pulse instead of a glitch on the pin.
  always_comb
  begin
    nxt_pinState = pinState_ff;
    nxt_pulseCnt = pulseCnt_ff;
    nxt_pinN     = 1'b1;
    case (pinState_ff)
      rtcal_pkg::PIN_IDLE:
      begin
        if (alarmEvent && pulseMode)
        begin
          nxt_pinState = rtcal_pkg::PIN_PULSE;
          nxt_pulseCnt = CNT_LOAD; // [RL5]
          nxt_pinN     = 1'b0;
        end
        else if (alarmEvent)
        begin
          nxt_pinState = rtcal_pkg::PIN_HOLD;
          nxt_pinN     = 1'b0; // [RL4]
        end
      end
      rtcal_pkg::PIN_HOLD:
      begin
        // The pin stays low until software clears the flag.
        if (flagClear && !alarmEvent)
        begin
          nxt_pinState = rtcal_pkg::PIN_IDLE;
        end
        else
        begin
          nxt_pinN = 1'b0; // [RL7]
        end
      end
      rtcal_pkg::PIN_PULSE:
      begin
        // The pulse ends on its own; the flag plays no part here.
        if (alarmEvent)
        begin
          nxt_pulseCnt = CNT_LOAD;
          nxt_pinN     = 1'b0;
        end
        else if (pulseCnt_ff == rtcal_pkg::CNT_ONE)
        begin
          nxt_pinState = rtcal_pkg::PIN_IDLE;
          nxt_pulseCnt = rtcal_pkg::CNT_ZERO;
        end
        else
        begin
          nxt_pulseCnt = pulseCnt_ff - rtcal_pkg::CNT_ONE; // [RL6]
          nxt_pinN     = 1'b0;
        end
      end
      default:
      begin
        nxt_pinState = rtcal_pkg::PIN_IDLE;
        nxt_pulseCnt = rtcal_pkg::CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinState_ff <= rtcal_pkg::PIN_IDLE;
      pulseCnt_ff <= rtcal_pkg::CNT_ZERO;
      pinN_ff     <= 1'b1;
    end
    else
    begin
      pinState_ff <= nxt_pinState;
      pulseCnt_ff <= nxt_pulseCnt;
      pinN_ff     <= nxt_pinN;
    end
  end

  assign alarmOrClockOutPinN = pinN_ff;

  // Read data is captured in the setup cycle so that it is stable
  // throughout the single access cycle.
  always_comb
  begin
    nxt_prdata = '0;
    case (apbReq.paddr)
      rtcal_pkg::OFS_SEC_MATCH: nxt_prdata[7:0] = secMatch_ff;
      rtcal_pkg::OFS_MIN_MATCH: nxt_prdata[7:0] = minMatch_ff;
      rtcal_pkg::OFS_HR_MATCH:  nxt_prdata[7:0] = hrMatch_ff;
      rtcal_pkg::OFS_DT_MATCH:  nxt_prdata[7:0] = dtMatch_ff;
      rtcal_pkg::OFS_MO_MATCH:  nxt_prdata[7:0] = moMatch_ff;
      rtcal_pkg::OFS_WD_MATCH:  nxt_prdata[7:0] = wdMatch_ff;
      rtcal_pkg::OFS_IRQ_CTRL:  nxt_prdata[7:0] = ctrl_ff;
      rtcal_pkg::OFS_STATUS:
        nxt_prdata[rtcal_pkg::STAT_AL0_BIT] = alarm0Flag_ff[0];
      rtcal_pkg::OFS_IRQ_EN:
        nxt_prdata[rtcal_pkg::STAT_AL0_BIT] = irqEn_ff[0];
      default:
        nxt_prdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata_ff  <= apbReq.pwrite ? '0 : nxt_prdata;
      pslverr_ff <= !mapped;
    end
  end

endmodule

// [rtl/rtcal_pkg.sv]
package rtcal_pkg;

  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 8;
  localparam int          REG_W         = 8;

  localparam logic [7:0]  OFS_SEC_MATCH = 8'h00;
  localparam logic [7:0]  OFS_MIN_MATCH = 8'h04;
  localparam logic [7:0]  OFS_HR_MATCH  = 8'h08;
  localparam logic [7:0]  OFS_DT_MATCH  = 8'h0C;
  localparam logic [7:0]  OFS_MO_MATCH  = 8'h10;
  localparam logic [7:0]  OFS_WD_MATCH  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CTRL  = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1C;
  localparam logic [7:0]  OFS_CLEAR     = 8'h20;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h24;

  localparam int          MATCH_EN_BIT  = 7;
  localparam int          MATCH_VAL_MSB = 6;
  localparam int          CTRL_ALARM0_ENABLE_BIT = 5;
  localparam int          CTRL_IM_BIT   = 7;
  localparam int          STAT_AL0_BIT  = 0;
  localparam int          STAT_W        = 1;

  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [0:0]  STAT_RST      = 1'h0;

  localparam int          CLK_PERIOD_NS = 5;
  localparam int          PULSE_NS      = 40;
  localparam int          PULSE_CYCLES  = (PULSE_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam int          CNT_W         = 8;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  localparam logic [7:0]  CNT_ONE       = 8'h01;

  typedef struct packed
  {
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] weekday;
  } rtcal_time_t;

  typedef struct packed
  {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } rtcal_apb_req_t;

  typedef struct packed
  {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } rtcal_apb_rsp_t;

  typedef enum logic [2:0]
  {
    PIN_IDLE  = 3'b001,
    PIN_HOLD  = 3'b010,
    PIN_PULSE = 3'b100
  } rtcal_pin_state_t;

endpackage

// [verification/rtcal_alarm0_chk.sv]
`timescale 1ns/100ps
module rtcal_alarm0_chk
(
  input wire logic                      clk,
  input wire logic                      rst,
  input wire rtcal_pkg::rtcal_apb_req_t apbReq,
  input wire rtcal_pkg::rtcal_apb_rsp_t apbRsp,
  input wire rtcal_pkg::rtcal_time_t    timeNow,
  input wire logic                      timeAdvance,
  input wire logic                      alarmOrClockOutPinN,
  input wire logic                      irq
);
  logic       acc;
  logic       clrWr;
  logic       pinN;
  logic [7:0] ctl_ff;
  assign acc = apbReq.psel && apbReq.penable;
  assign pinN = alarmOrClockOutPinN;
  assign clrWr = acc && apbReq.pwrite && apbReq.pwdata[0]
                 && apbReq.paddr == rtcal_pkg::OFS_CLEAR;
  // A shadow of control lets the mode be judged from the ports alone.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ctl_ff <= 8'h00;
    else if (acc && apbReq.pwrite && apbReq.paddr == rtcal_pkg::OFS_IRQ_CTRL)
      ctl_ff <= apbReq.pwdata[7:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pulseLow;
    (!pinN) [*8] ##1 pinN;
  endsequence
  AST_PREADY:
    assert property (apbRsp.pready) else $error("pready low");
  AST_EN_GATE:
    assert property ($fell(pinN) |-> $past(ctl_ff[5]))
    else $error("pin fell while alarm disabled");
  AST_ON_ADVANCE:
    assert property ($fell(pinN) |-> $past(timeAdvance))
    else $error("pin fell without time advance");
  AST_PULSE:
    assert property ($fell(pinN) && $past(ctl_ff[7]) |-> pulseLow)
    else $error("pulse width wrong");
  AST_HOLD:
    assert property (!pinN && !ctl_ff[7] && !clrWr |=> !pinN)
    else $error("single alarm released early");
  AST_RELEASE:
    assert property (clrWr && !ctl_ff[7] && !timeAdvance |=> pinN)
    else $error("pin not released by clear");
  AST_SLVERR:
    assert property (acc && apbReq.paddr > rtcal_pkg::OFS_IRQ_EN
                     |-> apbRsp.pslverr)
    else $error("no error on unmapped access");
  AST_UPPER:
    assert property (acc && !apbReq.pwrite |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind rtcal_alarm0 rtcal_alarm0_chk u_chk
(
  .clk(clk),
  .rst(rst),
  .apbReq(apbReq),
  .apbRsp(apbRsp),
  .timeNow(timeNow),
  .timeAdvance(timeAdvance),
  .alarmOrClockOutPinN(alarmOrClockOutPinN),
  .irq(irq)
);

// [verification/rtcal_host_model.sv]
`timescale 1ns/100ps
module rtcal_host_model
(
  input  wire logic                      clk,
  output rtcal_pkg::rtcal_apb_req_t      apbReq,
  input  wire rtcal_pkg::rtcal_apb_rsp_t apbRsp
);
  initial apbReq = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    @(posedge clk);
    while (apbRsp.pready !== 1'b1)
      @(posedge clk);
    q = apbRsp.prdata;
    // Released lines are scrambled so no stale value can be trusted.
    apbReq <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask
  task automatic setBits(input logic [7:0] a, input logic [7:0] m);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    xfer(1'b1, a, q | {24'h0, m}, q);
  endtask
endmodule

// [verification/rtcal_alarm0_tb.sv]
`timescale 1ns/100ps
module rtcal_alarm0_tb;
  logic                      clk;
  logic                      rst;
  rtcal_pkg::rtcal_apb_req_t apbReq;
  rtcal_pkg::rtcal_apb_rsp_t apbRsp;
  rtcal_pkg::rtcal_time_t    timeNow;
  logic                      timeAdvance;
  logic                      pinN;
  logic                      irq;
  logic [31:0]               q;
  logic                      p0;
  logic                      p1;
  int                        err_total;
  int                        n_checks;
  rtcal_host_model host (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));
  rtcal_alarm0 uut (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .timeNow(timeNow), .timeAdvance(timeAdvance),
    .alarmOrClockOutPinN(pinN), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    host.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  function automatic rtcal_pkg::rtcal_time_t tm(input logic [7:0] s,
                                                input logic [7:0] m);
    // Weekday is off the match value so a skipped field is exercised.
    return '{s, m, 8'h11, 8'h01, 8'h01, 8'h03};
  endfunction
  task automatic adv(input rtcal_pkg::rtcal_time_t t);
    @(posedge clk);
    timeNow <= t;
    timeAdvance <= 1'b1;
    @(posedge clk);
    timeAdvance <= 1'b0;
    #1 p0 = pinN;
    repeat (12) @(posedge clk);
    #1 p1 = pinN;
  endtask
  task automatic testReset;
    chk("pin", 32'h1, {31'h0, pinN});
    chk("irq", 32'h0, {31'h0, irq});
    rd(rtcal_pkg::OFS_IRQ_CTRL, 32'h0, "control");
    rd(rtcal_pkg::OFS_STATUS, 32'h0, "status");
    wr(8'h28, 32'hFF);
    rd(8'h28, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic testSingle;
    wr(rtcal_pkg::OFS_MIN_MATCH, 32'hB0);
    wr(rtcal_pkg::OFS_HR_MATCH, 32'h91);
    wr(rtcal_pkg::OFS_DT_MATCH, 32'h81);
    wr(rtcal_pkg::OFS_MO_MATCH, 32'h81);
    rd(rtcal_pkg::OFS_HR_MATCH, 32'h91, "hour match");
    adv(tm(8'h00, 8'h30));
    chk("pin disabled", 32'h1, {31'h0, p0});
    host.setBits(rtcal_pkg::OFS_IRQ_CTRL, 8'h20);
    adv(tm(8'h59, 8'h29));
    chk("pin early", 32'h1, {31'h0, p0});
    adv(tm(8'h00, 8'h30));
    chk("pin match", 32'h0, {31'h0, p0});
    chk("pin held", 32'h0, {31'h0, p1});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(rtcal_pkg::OFS_STATUS, 32'h1, "flag");
    wr(rtcal_pkg::OFS_IRQ_EN, 32'h1);
    @(posedge clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(rtcal_pkg::OFS_CLEAR, 32'h1);
    @(posedge clk);
    #1 chk("pin cleared", 32'h1, {31'h0, pinN});
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test single done");
  endtask
  task automatic testPulse;
    int i;
    for (i = 1; i < 5; i++)
      wr(8'(4 * i), 32'h0);
    wr(rtcal_pkg::OFS_SEC_MATCH, 32'hB0);
    host.setBits(rtcal_pkg::OFS_IRQ_CTRL, 8'h80);
    for (i = 0; i < 2; i++)
    begin
      adv(tm(8'h30, 8'(i)));
      chk("pulse", 32'h0, {31'h0, p0});
      chk("pulse end", 32'h1, {31'h0, p1});
      adv(tm(8'h31, 8'(i)));
      chk("no pulse", 32'h1, {31'h0, p0});
    end
    // The flag is left set on purpose between pulses.
    rd(rtcal_pkg::OFS_STATUS, 32'h1, "pulse flag");
    $display("test pulse done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    err_total = 0;
    n_checks = 0;
    rst = 1'b1;
    timeAdvance = 1'b0;
    timeNow = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    testReset();
    testSingle();
    testPulse();
    report_and_stop();
  end
  initial
  begin
    #50000;
    err_total++;
    report_and_stop();
  end
endmodule
